// file: rtl/tsr_consts.svh
// Constants for the temperature, test-tuning and reset register bank.
// Assumes 7-bit register addresses and 8-bit register data.
`ifndef TSR_CONSTS_SVH
`define TSR_CONSTS_SVH

// Register offsets
`define TSR_OFS_TEMP_CTRL   7'h4E
`define TSR_OFS_TEMP_RESULT 7'h4F
`define TSR_OFS_LNA         7'h58
`define TSR_OFS_PA_A        7'h5A
`define TSR_OFS_PA_B        7'h5C
`define TSR_OFS_FADE        7'h6F
`define TSR_OFS_AFC         7'h71

// Control/status field positions
`define TSR_BIT_TRIGGER     3
`define TSR_BIT_ACTIVE      2
`define TSR_CTRL_HI_FIXED   4'h0
`define TSR_CTRL_LO_FIXED   2'h1

// Reset values
`define TSR_RST_LNA         8'h1B
`define TSR_RST_PA_A        8'h55
`define TSR_RST_PA_B        8'h70
`define TSR_RST_FADE        8'h30
`define TSR_RST_AFC         8'h00
`define TSR_RST_RESULT      8'h00

// Decoded settings
`define TSR_LNA_HIGH_SENS   8'h2D
`define TSR_PA_A_BOOST      8'h5D
`define TSR_PA_B_BOOST      8'h7C
`define TSR_FADE_IMP_NARROW 8'h20
`define TSR_FADE_IMP_WIDE   8'h30
`define TSR_AFC_STEP_HZ     17'sh001E8

// Timing
`define TSR_CLK_MHZ         125
`define TSR_MEAS_TIME_US    100
`define TSR_READY_TIME_US   5000
`define TSR_MEAS_CYCLES     (`TSR_MEAS_TIME_US * `TSR_CLK_MHZ)
`define TSR_READY_CYCLES    (`TSR_READY_TIME_US * `TSR_CLK_MHZ)

`endif

// file: rtl/tsr_pkg.sv
// Types used by the measurement sequencer of the register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package tsr_pkg;
  typedef enum logic [0:0] {
    TSR_MEAS_IDLE = 1'b0,
    TSR_MEAS_RUN  = 1'b1
  } tsr_meas_st_t;
endpackage

// file: rtl/tsr_meas_seq.sv
// Temperature measurement sequencer: runs a timed conversion and latches the reading.
// Assumes a one-cycle start pulse and a raw reading valid at the end of the run.
`timescale 1ns/1ns
`default_nettype none
`include "tsr_consts.svh"
module tsr_meas_seq #(
  parameter int MEAS_CYCLES = `TSR_MEAS_CYCLES
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_sync_clr,
  input  wire logic       i_start,
  input  wire logic [7:0] i_temp_raw,
  output logic            o_active,
  output logic [7:0]      o_result
);
  localparam int CW = $clog2(MEAS_CYCLES + 1);

  typedef struct packed {
    tsr_pkg::tsr_meas_st_t st;
    logic [CW-1:0]         cnt;
    logic [7:0]            result;
  } tsr_seq_t;

  tsr_seq_t s_q;
  tsr_seq_t s_d;

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      tsr_pkg::TSR_MEAS_IDLE: begin
        if (i_start) begin
          s_d.st  = tsr_pkg::TSR_MEAS_RUN;
          s_d.cnt = '0;
        end
      end
      tsr_pkg::TSR_MEAS_RUN: begin
        s_d.cnt = s_q.cnt + CW'(1);
        if (s_q.cnt == CW'(MEAS_CYCLES - 1)) begin
          s_d.st     = tsr_pkg::TSR_MEAS_IDLE;
          s_d.result = i_temp_raw;
        end
      end
      default: s_d.st = tsr_pkg::TSR_MEAS_IDLE;
    endcase
    if (i_sync_clr) begin
      s_d.st     = tsr_pkg::TSR_MEAS_IDLE;
      s_d.cnt    = '0;
      s_d.result = `TSR_RST_RESULT;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q.st     <= tsr_pkg::TSR_MEAS_IDLE;
      s_q.cnt    <= '0;
      s_q.result <= `TSR_RST_RESULT;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_active = (s_q.st == tsr_pkg::TSR_MEAS_RUN);
  assign o_result = s_q.result;

  property p_meas_latch;
    @(posedge i_core_clk) disable iff (i_rst)
      $fell(o_active) && !$past(i_sync_clr) |-> o_result == $past(i_temp_raw);
  endproperty
  a_meas_latch: assert property (p_meas_latch) else $error("reading not latched at end");

  property p_meas_hold;
    @(posedge i_core_clk) disable iff (i_rst || i_sync_clr)
      $rose(o_active) |-> o_active [*2];
  endproperty
  a_meas_hold: assert property (p_meas_hold) else $error("measurement ended too early");
endmodule
`default_nettype wire

// file: rtl/tsr_regs.sv
// Temperature, receiver/transmitter test-tuning and reset sequencing register bank.
// Assumes the serial front end presents byte reads/writes on a synchronous register port.
`timescale 1ns/1ns
`default_nettype none
`include "tsr_consts.svh"
module tsr_regs #(
  parameter int MEAS_CYCLES  = `TSR_MEAS_CYCLES,
  parameter int READY_CYCLES = `TSR_READY_CYCLES
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_reset_pin,
  input  wire logic [6:0]  i_reg_addr,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic [7:0]  i_temp_raw,
  input  wire logic        i_narrow_mod_correction_on,
  output logic [7:0]       o_reg_rdata,
  output logic             o_temp_measure_active,
  output logic             o_high_sensitivity,
  output logic [7:0]       o_pa_tune_a,
  output logic [7:0]       o_pa_tune_b,
  output logic             o_boost_power_output_20dbm,
  output logic             o_fading_improved,
  output logic signed [16:0] o_freq_corr_hz,
  output logic             o_device_ready,
  output logic             o_reference_clock_out
);
  localparam int RW = $clog2(READY_CYCLES + 1);

  typedef struct packed {
    logic [7:0]        lna;
    logic [7:0]        pa_a;
    logic [7:0]        pa_b;
    logic [7:0]        fade;
    logic [7:0]        afc;
    logic [7:0]        rdata;
    logic              start;
    logic              hi_sens;
    logic              boost;
    logic              fade_imp;
    logic signed [16:0] corr;
    logic [RW-1:0]     rdy_cnt;
    logic              ready;
    logic              reference_clock_out;
  } tsr_regs_t;

  tsr_regs_t  s_q;
  tsr_regs_t  s_d;
  logic       meas_active;
  logic [7:0] meas_result;
  logic [7:0] ctrl_rd;

  tsr_meas_seq #(
    .MEAS_CYCLES (MEAS_CYCLES)
  ) u_seq (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_sync_clr (i_reset_pin),
    .i_start    (s_q.start),
    .i_temp_raw (i_temp_raw),
    .o_active   (meas_active),
    .o_result   (meas_result)
  );

  // Trigger kept only as the one-cycle start pulse, so it reads as zero
  assign ctrl_rd = {`TSR_CTRL_HI_FIXED, 1'b0, meas_active, `TSR_CTRL_LO_FIXED};

  always_comb begin
    s_d       = s_q;
    s_d.start = 1'b0;
    if (i_reg_wr) begin
      case (i_reg_addr)
        `TSR_OFS_TEMP_CTRL: s_d.start = i_reg_wdata[`TSR_BIT_TRIGGER] & ~meas_active;
        `TSR_OFS_LNA:       s_d.lna   = i_reg_wdata;
        `TSR_OFS_PA_A:      s_d.pa_a  = i_reg_wdata;
        `TSR_OFS_PA_B:      s_d.pa_b  = i_reg_wdata;
        `TSR_OFS_FADE:      s_d.fade  = i_reg_wdata;
        `TSR_OFS_AFC:       s_d.afc   = i_reg_wdata;
        default:            s_d.start = 1'b0;
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        `TSR_OFS_TEMP_CTRL:   s_d.rdata = ctrl_rd;
        `TSR_OFS_TEMP_RESULT: s_d.rdata = meas_result;
        `TSR_OFS_LNA:         s_d.rdata = s_q.lna;
        `TSR_OFS_PA_A:        s_d.rdata = s_q.pa_a;
        `TSR_OFS_PA_B:        s_d.rdata = s_q.pa_b;
        `TSR_OFS_FADE:        s_d.rdata = s_q.fade;
        `TSR_OFS_AFC:         s_d.rdata = s_q.afc;
        default:              s_d.rdata = 8'h00;
      endcase
    end
    // Decodes follow the new register values in the same edge
    s_d.hi_sens  = (s_d.lna == `TSR_LNA_HIGH_SENS);
    s_d.boost    = (s_d.pa_a == `TSR_PA_A_BOOST) && (s_d.pa_b == `TSR_PA_B_BOOST);
    s_d.fade_imp = (s_d.fade == `TSR_FADE_IMP_NARROW) || (s_d.fade == `TSR_FADE_IMP_WIDE);
    // Offset taken as signed so the correction can pull either way
    s_d.corr = i_narrow_mod_correction_on ? 17'(signed'(s_q.afc) * `TSR_AFC_STEP_HZ) : 17'sh00000;
    // Clock-out only starts once the settle time has passed
    if (!s_q.ready) begin
      s_d.rdy_cnt = s_q.rdy_cnt + RW'(1);
      s_d.ready   = (s_q.rdy_cnt == RW'(READY_CYCLES - 1));
    end
    s_d.reference_clock_out = s_q.ready & ~s_q.reference_clock_out;
    if (i_reset_pin) begin
      s_d = '0;
      s_d.lna  = `TSR_RST_LNA;
      s_d.pa_a = `TSR_RST_PA_A;
      s_d.pa_b = `TSR_RST_PA_B;
      s_d.fade = `TSR_RST_FADE;
      s_d.afc  = `TSR_RST_AFC;
      s_d.fade_imp = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      s_q          <= '0;
      s_q.lna      <= `TSR_RST_LNA;
      s_q.pa_a     <= `TSR_RST_PA_A;
      s_q.pa_b     <= `TSR_RST_PA_B;
      s_q.fade     <= `TSR_RST_FADE;
      s_q.afc      <= `TSR_RST_AFC;
      s_q.fade_imp <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_reg_rdata           = s_q.rdata;
  assign o_temp_measure_active = meas_active;
  assign o_high_sensitivity    = s_q.hi_sens;
  assign o_pa_tune_a           = s_q.pa_a;
  assign o_pa_tune_b           = s_q.pa_b;
  assign o_boost_power_output_20dbm      = s_q.boost;
  assign o_fading_improved     = s_q.fade_imp;
  assign o_freq_corr_hz        = s_q.corr;
  assign o_device_ready        = s_q.ready;
  assign o_reference_clock_out = s_q.reference_clock_out;

  property p_trig_start;
    @(posedge i_core_clk) disable iff (i_rst)
      i_reg_wr && i_reg_addr == `TSR_OFS_TEMP_CTRL && i_reg_wdata[`TSR_BIT_TRIGGER] && !meas_active
      && !i_reset_pin ##1 !i_reset_pin |-> ##1 o_temp_measure_active;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger did not start measurement");

  property p_ctrl_read;
    @(posedge i_core_clk) disable iff (i_rst)
      i_reg_rd && i_reg_addr == `TSR_OFS_TEMP_CTRL && !i_reset_pin
      |=> o_reg_rdata == {4'h0, 1'b0, $past(meas_active), 2'h1};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");

  property p_result_read;
    @(posedge i_core_clk) disable iff (i_rst)
      i_reg_rd && i_reg_addr == `TSR_OFS_TEMP_RESULT && !i_reset_pin |=> o_reg_rdata == $past(meas_result);
  endproperty
  a_result_read: assert property (p_result_read) else $error("reading readback wrong");

  property p_hi_sens;
    @(posedge i_core_clk) disable iff (i_rst)
      i_reg_wr && i_reg_addr == `TSR_OFS_LNA && !i_reset_pin
      |=> o_high_sensitivity == ($past(i_reg_wdata) == 8'h2D);
  endproperty
  a_hi_sens: assert property (p_hi_sens) else $error("sensitivity decode wrong");

  property p_boost;
    @(posedge i_core_clk) disable iff (i_rst)
      o_boost_power_output_20dbm |-> o_pa_tune_a == 8'h5D && o_pa_tune_b == 8'h7C;
  endproperty
  a_boost: assert property (p_boost) else $error("boost without both tune values");

  property p_fade;
    @(posedge i_core_clk) disable iff (i_rst)
      i_reg_wr && i_reg_addr == `TSR_OFS_FADE && !i_reset_pin
      |=> o_fading_improved == ($past(i_reg_wdata) == 8'h20 || $past(i_reg_wdata) == 8'h30);
  endproperty
  a_fade: assert property (p_fade) else $error("fading decode wrong");

  property p_corr;
    @(posedge i_core_clk) disable iff (i_rst)
      !$past(i_reset_pin) |-> o_freq_corr_hz == ($past(i_narrow_mod_correction_on)
        ? 17'($signed($past(s_q.afc)) * 17'sd488) : 17'sd0);
  endproperty
  a_corr: assert property (p_corr) else $error("frequency correction wrong");

  property p_pin_reset;
    @(posedge i_core_clk) disable iff (i_rst)
      i_reset_pin |=> o_high_sensitivity == 1'b0 && !o_device_ready && !o_temp_measure_active
        && o_pa_tune_a == 8'h55 && o_pa_tune_b == 8'h70;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("reset pin did not restore defaults");

  property p_reference_clock_out_quiet;
    @(posedge i_core_clk) disable iff (i_rst)
      !o_device_ready |=> !o_reference_clock_out;
  endproperty
  a_reference_clock_out_quiet: assert property (p_reference_clock_out_quiet) else $error("clock-out before ready");

  c_meas_done: cover property (@(posedge i_core_clk) disable iff (i_rst) $fell(o_temp_measure_active));
  c_hi_sens:   cover property (@(posedge i_core_clk) disable iff (i_rst) $rose(o_high_sensitivity));
  c_boost:     cover property (@(posedge i_core_clk) disable iff (i_rst) $rose(o_boost_power_output_20dbm));
  c_ready:     cover property (@(posedge i_core_clk) disable iff (i_rst) $rose(o_device_ready));
endmodule
`default_nettype wire

// file: dv/tsr_host.sv
// Host model: byte register port and reset pin of the bank.
// Assumes the bank samples requests on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module tsr_host (
  input  wire logic       i_core_clk,
  input  wire logic [7:0] i_reg_rdata,
  input  wire logic       i_reference_clock_out,
  output logic [6:0]      o_reg_addr,
  output logic            o_reg_wr,
  output logic            o_reg_rd,
  output logic [7:0]      o_reg_wdata,
  output logic            o_reset_pin
);
  initial begin
    o_reg_addr = 7'h00;
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_wdata = 8'h00;
    o_reset_pin = 1'b0;
  end
  // Released lines show the inverse, never a stale value
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_reg_addr <= a;
    o_reg_wdata <= d;
    o_reg_wr <= 1'b1;
    @(posedge i_core_clk);
    o_reg_wr <= 1'b0;
    o_reg_addr <= ~a;
    o_reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    o_reg_addr <= a;
    o_reg_rd <= 1'b1;
    @(posedge i_core_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a;
    @(posedge i_core_clk);
    #1 d = i_reg_rdata;
  endtask
  task automatic pulse_reset(input int n);
    @(posedge i_core_clk);
    o_reset_pin <= 1'b1;
    repeat (n) @(posedge i_core_clk);
    o_reset_pin <= 1'b0;
  endtask
  // No register traffic until clock-out moves
  task automatic wait_ready(output bit ok);
    logic p;
    p = i_reference_clock_out;
    ok = 1'b0;
    repeat (200) begin
      @(posedge i_core_clk);
      if (!ok && i_reference_clock_out !== p) ok = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the register bank, against a queue-free integer model.
// Assumes short measurement and ready counts set below.
`timescale 1ns/1ns
`default_nettype none
`include "tsr_consts.svh"
module tb_top;
  localparam int MEAS = 8;
  logic i_core_clk = 1'b0, i_rst = 1'b1, i_reset_pin, i_reg_wr, i_reg_rd;
  logic [6:0] i_reg_addr;
  logic [7:0] i_reg_wdata, o_reg_rdata, o_pa_tune_a, o_pa_tune_b;
  logic [7:0] i_temp_raw = 8'h00;
  logic i_narrow_mod_correction_on = 1'b0;
  logic o_temp_measure_active, o_high_sensitivity, o_boost_power_output_20dbm, o_fading_improved;
  logic o_device_ready, o_reference_clock_out;
  logic signed [16:0] o_freq_corr_hz;
  int errors = 0, check_count = 0, run_len = 0, last_len = 0;
  int er[int];
  int wl[$];
  bit ok;
  always #4 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    if (o_temp_measure_active) run_len <= run_len + 1;
    else if (run_len != 0) begin
      last_len <= run_len;
      run_len <= 0;
    end
  end
  tsr_host host (.i_core_clk(i_core_clk), .i_reg_rdata(o_reg_rdata), .i_reference_clock_out(o_reference_clock_out),
    .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_wdata(i_reg_wdata),
    .o_reset_pin(i_reset_pin));
  tsr_regs #(.MEAS_CYCLES(MEAS), .READY_CYCLES(16)) dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_reset_pin(i_reset_pin), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .i_temp_raw(i_temp_raw), .i_narrow_mod_correction_on(i_narrow_mod_correction_on),
    .o_reg_rdata(o_reg_rdata), .o_temp_measure_active(o_temp_measure_active), .o_high_sensitivity(o_high_sensitivity),
    .o_pa_tune_a(o_pa_tune_a), .o_pa_tune_b(o_pa_tune_b), .o_boost_power_output_20dbm(o_boost_power_output_20dbm),
    .o_fading_improved(o_fading_improved), .o_freq_corr_hz(o_freq_corr_hz), .o_device_ready(o_device_ready),
    .o_reference_clock_out(o_reference_clock_out));
  task automatic final_report();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input int a);
    logic [7:0] d;
    host.rd(7'(a), d);
    chk(17'(d), 17'(er.exists(a) ? er[a] : 0));
  endtask
  task automatic chk_out();
    int v;
    v = er[`TSR_OFS_AFC] > 127 ? er[`TSR_OFS_AFC] - 256 : er[`TSR_OFS_AFC];
    chk(17'(o_high_sensitivity), 17'(er[`TSR_OFS_LNA] == 8'h2D));
    chk(17'(o_pa_tune_a), 17'(er[`TSR_OFS_PA_A]));
    chk(17'(o_pa_tune_b), 17'(er[`TSR_OFS_PA_B]));
    chk(17'(o_boost_power_output_20dbm), 17'(er[`TSR_OFS_PA_A] == 8'h5D && er[`TSR_OFS_PA_B] == 8'h7C));
    chk(17'(o_fading_improved), 17'(er[`TSR_OFS_FADE] == 8'h20 || er[`TSR_OFS_FADE] == 8'h30));
    chk(17'(o_freq_corr_hz), i_narrow_mod_correction_on ? 17'(v * 488) : 17'h0);
  endtask
  task automatic model_reset();
    er[`TSR_OFS_TEMP_CTRL] = 8'h01;
    er[`TSR_OFS_TEMP_RESULT] = 8'h00;
    er[`TSR_OFS_LNA] = 8'h1B;
    er[`TSR_OFS_PA_A] = 8'h55;
    er[`TSR_OFS_PA_B] = 8'h70;
    er[`TSR_OFS_FADE] = 8'h30;
    er[`TSR_OFS_AFC] = 8'h00;
  endtask
  task automatic check_all();
    foreach (er[a]) chk_reg(a);
    chk_reg(8'h50);
    chk_out();
  endtask
  task automatic wait_act(input logic v);
    int n;
    n = 0;
    while (o_temp_measure_active !== v) begin
      @(posedge i_core_clk);
      #1 n++;
      if (n > 40) begin
        chk(17'h0, 17'h1);
        final_report();
      end
    end
  endtask
  task automatic measure(input bit peek);
    @(posedge i_core_clk);
    i_temp_raw <= 8'($urandom);
    host.wr(`TSR_OFS_TEMP_CTRL, 8'hFF);
    wait_act(1'b1);
    // Control reads active mid-run, and a second trigger while active is ignored
    if (peek) begin
      er[`TSR_OFS_TEMP_CTRL] = 8'h05;
      chk_reg(`TSR_OFS_TEMP_CTRL);
      host.wr(`TSR_OFS_TEMP_CTRL, 8'h08);
      er[`TSR_OFS_TEMP_CTRL] = 8'h01;
    end
    wait_act(1'b0);
    @(posedge i_core_clk);
    #1 chk(17'(last_len), 17'(MEAS));
    er[`TSR_OFS_TEMP_RESULT] = int'(i_temp_raw);
    chk_reg(`TSR_OFS_TEMP_RESULT);
    chk_reg(`TSR_OFS_TEMP_CTRL);
  endtask
  initial begin
    void'($urandom(32'hd5c4));
    model_reset();
    repeat (8) @(posedge i_core_clk);
    i_rst <= 1'b0;
    host.wait_ready(ok);
    chk(17'(ok), 17'h1);
    // Ready never seen: no point in register traffic
    if (!ok) final_report();
    check_all();
    $display("test reset_defaults done");
    wl = '{`TSR_OFS_LNA, 8'h2D, `TSR_OFS_PA_A, 8'h5D, `TSR_OFS_PA_B, 8'h7C, `TSR_OFS_PA_A, 8'h55,
           `TSR_OFS_FADE, 8'h00, `TSR_OFS_FADE, 8'h20, `TSR_OFS_FADE, 8'h30, `TSR_OFS_AFC, 8'h80,
           `TSR_OFS_AFC, $urandom & 8'hFF, `TSR_OFS_LNA, 8'h1B, `TSR_OFS_LNA, $urandom & 8'hFF,
           `TSR_OFS_TEMP_RESULT, 8'hA5, `TSR_OFS_TEMP_CTRL, 8'hF7, 8'h50, 8'h3C, `TSR_OFS_PA_B, 8'h70};
    for (int i = 0; i < wl.size(); i += 2) begin
      @(posedge i_core_clk);
      i_narrow_mod_correction_on <= 1'($urandom);
      host.wr(7'(wl[i]), 8'(wl[i + 1]));
      // Read-only and unmapped places keep their values
      if (er.exists(wl[i]) && wl[i] > `TSR_OFS_TEMP_RESULT) er[wl[i]] = wl[i + 1];
      chk_reg(wl[i]);
      chk_out();
    end
    $display("test write_decode done");
    measure(1'b0);
    measure(1'b1);
    $display("test measurement done");
    host.wr(`TSR_OFS_LNA, 8'h2D);
    host.wr(`TSR_OFS_TEMP_CTRL, 8'h08);
    wait_act(1'b1);
    host.pulse_reset(4);
    @(posedge i_core_clk);
    #1 chk(17'(o_device_ready), 17'h0);
    model_reset();
    host.wait_ready(ok);
    chk(17'(ok), 17'h1);
    if (!ok) final_report();
    check_all();
    $display("test pin_reset done");
    final_report();
  end
endmodule
`default_nettype wire
